// ==== rtl/lvsl_link.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "lvsl_params.svh"

module lvsl_link
  import lvsl_pkg::*;
#(
  parameter logic [31:0] PLL_LOCK_CYCLES = 32'(`LVSL_PLL_LOCK_CYCLES),
  parameter logic [15:0] RX_FRAME_GAP_CYCLES = `LVSL_RX_FRAME_GAP_CYCLES
) (
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic link_clk,
  // Transmitter parallel side
  input wire lvsl_pixel_t parallel_tx_inputs,
  input wire logic tx_shift_clock_in,
  input wire logic strobe_edge_select,
  input wire logic tx_sleep_request_n,
  // Transmitter serial side
  output lvsl_data_pairs_t serial_data_out_pairs,
  output logic [`LVSL_CHANNELS-1:0] serial_data_out_oe,
  output lvsl_clk_pair_t forwarded_clock_out,
  output logic forwarded_clock_out_oe,
  // Receiver serial side
  input wire lvsl_data_pairs_t serial_data_in_pairs,
  input wire lvsl_clk_pair_t forwarded_clock_in,
  input wire logic rx_sleep_request_n,
  // Receiver parallel side
  output lvsl_pixel_t parallel_rx_outputs,
  output logic rx_shift_clock_out,
  // Status
  output logic tx_locked,
  output logic rx_locked
);

  localparam int unsigned PIN_W = `LVSL_WORD_BITS + 4;

  // ========================================================
  // Slot decode used by the transmitter half
  function automatic logic [`LVSL_CHANNELS-1:0] slot_bits(
    input logic [`LVSL_WORD_BITS-1:0] word,
    input logic [2:0] slot
  );
    logic [`LVSL_CHANNELS-1:0] bits;
    bits = '0;
    for (int c = 0; c < `LVSL_CHANNELS; c++) begin
      bits[c] = word[c * `LVSL_SLOTS + int'(slot)];
    end
    return bits;
  endfunction

  function automatic logic [2:0] slot_after(input logic [2:0] slot);
    return (slot == `LVSL_LAST_SLOT) ? `LVSL_FIRST_SLOT : 3'(slot + 3'h1);
  endfunction

  // ========================================================
  // Reference domain pin synchronisers
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_sync;
  lvsl_pixel_t tx_data_s;
  logic tx_clk_s;
  logic edge_sel_s;
  logic tx_awake_s;
  logic rx_awake_s;

  assign pin_raw = {rx_sleep_request_n, tx_sleep_request_n,
                    strobe_edge_select, tx_shift_clock_in,
                    parallel_tx_inputs};

  lvsl_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .clk(ref_clk),
    .rst_n(rstn),
    .din(pin_raw),
    .dout(pin_sync)
  );

  assign tx_data_s = lvsl_pixel_t'(pin_sync[`LVSL_WORD_BITS-1:0]);
  assign tx_clk_s = pin_sync[`LVSL_WORD_BITS];
  // Reset-low sync stands in for pull-down
  assign edge_sel_s = pin_sync[`LVSL_WORD_BITS+1];
  assign tx_awake_s = pin_sync[`LVSL_WORD_BITS+2];
  assign rx_awake_s = pin_sync[`LVSL_WORD_BITS+3];

  // ========================================================
  // Transmitter strobe and capture
  logic tx_clk_d_reg;
  logic tx_rise;
  logic tx_fall;
  logic tx_strobe;
  logic tx_capture;
  logic tx_wr_idx_reg;
  lvsl_pixel_t tx_buf_reg [2];

  assign tx_rise = tx_clk_s & ~tx_clk_d_reg;
  assign tx_fall = ~tx_clk_s & tx_clk_d_reg;
  assign tx_strobe = edge_sel_s ? tx_rise : tx_fall;
  assign tx_capture = tx_strobe & tx_awake_s & tx_locked;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tx_clk_d_reg <= 1'b0;
    end else begin
      tx_clk_d_reg <= tx_clk_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tx_wr_idx_reg <= 1'b0;
      tx_buf_reg[0] <= '0;
      tx_buf_reg[1] <= '0;
    end else if (tx_capture) begin
      tx_wr_idx_reg <= ~tx_wr_idx_reg;
      tx_buf_reg[~tx_wr_idx_reg] <= tx_data_s;
    end
  end

  // Gap sized for 20 MHz slowest clock
  lvsl_lock_timer #(
    .LOCK_CYCLES(PLL_LOCK_CYCLES),
    .GAP_CYCLES(16'(`LVSL_SHIFT_GAP_CYCLES))
  ) u_tx_lock (
    .clk(ref_clk),
    .rst_n(rstn),
    .enable(tx_awake_s),
    .activity(tx_rise | tx_fall),
    .locked(tx_locked)
  );

  // ========================================================
  // Link domain reset and crossings
  logic [1:0] link_rst_pipe_reg;
  logic link_rst_n;
  logic [1:0] tx_ctl_raw;
  logic [1:0] tx_ctl_link;
  logic tx_rd_idx;
  logic tx_run;

  always_ff @(posedge link_clk) begin
    link_rst_pipe_reg <= {link_rst_pipe_reg[0], rstn};
  end

  assign link_rst_n = link_rst_pipe_reg[1];
  assign tx_ctl_raw = {tx_awake_s & tx_locked, tx_wr_idx_reg};

  lvsl_sync #(
    .WIDTH(2)
  ) u_tx_ctl_sync (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .din(tx_ctl_raw),
    .dout(tx_ctl_link)
  );

  assign tx_rd_idx = tx_ctl_link[0];
  assign tx_run = tx_ctl_link[1];

  // ========================================================
  // Transmitter serialiser
  logic [2:0] tx_slot_reg;
  logic [2:0] tx_slot_next;
  lvsl_pixel_t tx_word_reg;
  lvsl_pixel_t tx_word_src;
  logic [`LVSL_CHANNELS-1:0] tx_bits;
  logic [`LVSL_SLOTS-1:0] fwd_pattern;
  logic fwd_level;
  lvsl_data_pairs_t data_out_reg;
  logic [`LVSL_CHANNELS-1:0] data_oe_reg;
  lvsl_clk_pair_t fwd_out_reg;
  logic fwd_oe_reg;

  assign tx_slot_next = slot_after(tx_slot_reg);
  assign tx_word_src = (tx_slot_reg == `LVSL_LAST_SLOT) ?
                       tx_buf_reg[tx_rd_idx] : tx_word_reg;
  // Channel c slot s carries bit c*7+s
  assign tx_bits = slot_bits(tx_word_src, tx_slot_next);
  assign fwd_pattern = `LVSL_FWD_CLK_PATTERN;
  assign fwd_level = fwd_pattern[tx_slot_next];

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      tx_slot_reg <= `LVSL_FIRST_SLOT;
      tx_word_reg <= '0;
    end else begin
      tx_slot_reg <= tx_slot_next;
      tx_word_reg <= tx_word_src;
    end
  end

  // Three data pairs and a clock pair
  // One link edge after the sync
  always_ff @(posedge link_clk) begin
    if (!link_rst_n || !tx_run) begin
      data_out_reg <= '0;
      data_oe_reg <= '0;
      fwd_out_reg <= '0;
      fwd_oe_reg <= 1'b0;
    end else begin
      data_out_reg.p <= tx_bits;
      data_out_reg.n <= ~tx_bits;
      data_oe_reg <= '1;
      fwd_out_reg.p <= fwd_level;
      fwd_out_reg.n <= ~fwd_level;
      fwd_oe_reg <= 1'b1;
    end
  end

  assign serial_data_out_pairs = data_out_reg;
  assign serial_data_out_oe = data_oe_reg;
  assign forwarded_clock_out = fwd_out_reg;
  assign forwarded_clock_out_oe = fwd_oe_reg;

  // ========================================================
  // Receiver serial inputs in the link domain
  logic [`LVSL_CHANNELS:0] rx_pin_raw;
  logic [`LVSL_CHANNELS:0] rx_pin_reg;
  logic [`LVSL_CHANNELS-1:0] rx_bits;
  logic rx_fclk;

  // Three data pairs and a clock pair in
  assign rx_pin_raw = {forwarded_clock_in.p & ~forwarded_clock_in.n,
                       serial_data_in_pairs.p & ~serial_data_in_pairs.n};

  // Link-clock timed, one stage; a filter would drop one-slot bits
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      rx_pin_reg <= '0;
    end else begin
      rx_pin_reg <= rx_pin_raw;
    end
  end

  assign rx_bits = rx_pin_reg[`LVSL_CHANNELS-1:0];
  assign rx_fclk = rx_pin_reg[`LVSL_CHANNELS];

  // ========================================================
  // Receiver deserialiser
  logic rx_fclk_d_reg;
  logic rx_frame_start;
  logic [2:0] rx_slot_reg;
  logic [2:0] rx_slot_cur;
  logic [`LVSL_WORD_BITS-1:0] rx_acc_reg;
  logic [`LVSL_WORD_BITS-1:0] rx_acc_next;
  logic [`LVSL_WORD_BITS-1:0] rx_word_reg;
  logic rx_tgl_reg;
  logic rx_last;

  // Frame starts where the forwarded clock rises
  assign rx_frame_start = rx_fclk & ~rx_fclk_d_reg;
  assign rx_slot_cur = rx_frame_start ? `LVSL_FIRST_SLOT : rx_slot_reg;
  assign rx_last = (rx_slot_cur == `LVSL_LAST_SLOT);

  // One sample per slot, zero to six
  // Same slot map as the transmitter
  for (genvar c = 0; c < `LVSL_CHANNELS; c++) begin : g_rx_ch
    for (genvar s = 0; s < `LVSL_SLOTS; s++) begin : g_rx_slot
      assign rx_acc_next[c * `LVSL_SLOTS + s] =
        (rx_slot_cur == 3'(s)) ? rx_bits[c] :
        rx_acc_reg[c * `LVSL_SLOTS + s];
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      rx_fclk_d_reg <= 1'b0;
      rx_slot_reg <= `LVSL_IDLE_SLOT;
      rx_acc_reg <= '0;
    end else begin
      rx_fclk_d_reg <= rx_fclk;
      rx_acc_reg <= rx_acc_next;
      if (rx_slot_cur != `LVSL_IDLE_SLOT) begin
        rx_slot_reg <= 3'(rx_slot_cur + 3'h1);
      end
    end
  end

  // Word holds for a whole frame while the reference side reads it
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      rx_word_reg <= '0;
      rx_tgl_reg <= 1'b0;
    end else if (rx_last) begin
      rx_word_reg <= rx_acc_next;
      rx_tgl_reg <= ~rx_tgl_reg;
    end
  end

  // ========================================================
  // Receiver word into the reference domain
  logic rx_tgl_s;
  logic rx_tgl_d_reg;
  logic rx_new;

  lvsl_sync #(
    .WIDTH(1)
  ) u_rx_tgl_sync (
    .clk(ref_clk),
    .rst_n(rstn),
    .din(rx_tgl_reg),
    .dout(rx_tgl_s)
  );

  assign rx_new = rx_tgl_s ^ rx_tgl_d_reg;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rx_tgl_d_reg <= 1'b0;
    end else begin
      rx_tgl_d_reg <= rx_tgl_s;
    end
  end

  // Lock on a steady run of frames
  lvsl_lock_timer #(
    .LOCK_CYCLES(PLL_LOCK_CYCLES),
    .GAP_CYCLES(RX_FRAME_GAP_CYCLES)
  ) u_rx_lock (
    .clk(ref_clk),
    .rst_n(rstn),
    .enable(rx_awake_s),
    .activity(rx_new),
    .locked(rx_locked)
  );

  // ========================================================
  // Receiver parallel outputs and shift clock
  lvsl_strobe_state_t stb_state_reg;
  lvsl_strobe_state_t stb_state_next;
  logic [3:0] stb_cnt_reg;
  logic stb_done;
  logic rx_run;
  lvsl_pixel_t rx_out_reg;
  logic rx_clk_reg;

  assign rx_run = rx_awake_s & rx_locked;
  assign stb_done = (stb_cnt_reg == `LVSL_RX_STROBE_HIGH_CYCLES);

  always_comb begin
    stb_state_next = stb_state_reg;
    unique case (stb_state_reg)
      STB_IDLE: begin
        if (rx_new) begin
          stb_state_next = STB_HIGH;
        end
      end
      STB_HIGH: begin
        if (stb_done) begin
          stb_state_next = STB_IDLE;
        end
      end
    endcase
  end

  // Cleared one cycle after sync
  // Data set at rise, valid at fall
  always_ff @(posedge ref_clk) begin
    if (!rstn || !rx_run) begin
      stb_state_reg <= STB_IDLE;
      stb_cnt_reg <= '0;
      rx_out_reg <= '0;
      rx_clk_reg <= 1'b0;
    end else begin
      stb_state_reg <= stb_state_next;
      if (stb_state_reg == STB_IDLE && rx_new) begin
        rx_out_reg <= lvsl_pixel_t'(rx_word_reg);
        rx_clk_reg <= 1'b1;
        stb_cnt_reg <= '0;
      end else if (stb_state_reg == STB_HIGH) begin
        stb_cnt_reg <= 4'(stb_cnt_reg + 4'h1);
        if (stb_done) begin
          rx_clk_reg <= 1'b0;
        end
      end
    end
  end

  assign parallel_rx_outputs = rx_out_reg;
  assign rx_shift_clock_out = rx_clk_reg;

endmodule

`default_nettype wire

// ==== rtl/lvsl_lock_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Lock timer: locks after a run of steady activity
module lvsl_lock_timer #(
  parameter logic [31:0] LOCK_CYCLES = 32'd1000,
  parameter logic [15:0] GAP_CYCLES = 16'd16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic activity,
  // Status
  output logic locked
);

  logic [31:0] count_reg;
  logic [15:0] gap_reg;
  logic locked_reg;
  logic stalled;

  assign stalled = (gap_reg == GAP_CYCLES);
  assign locked = locked_reg;

  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      gap_reg <= '0;
    end else if (activity) begin
      gap_reg <= '0;
    end else if (!stalled) begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !enable || stalled) begin
      count_reg <= '0;
      locked_reg <= 1'b0;
    end else if (count_reg >= LOCK_CYCLES) begin
      locked_reg <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/lvsl_params.svh ====
`ifndef LVSL_PARAMS_SVH
`define LVSL_PARAMS_SVH

// ==========================================================
// Link geometry
`define LVSL_COLOR_BITS 6
`define LVSL_CHANNELS 3
`define LVSL_SLOTS 7
`define LVSL_WORD_BITS 21
`define LVSL_FIRST_SLOT 3'h0
`define LVSL_LAST_SLOT 3'h6
`define LVSL_IDLE_SLOT 3'h7
// Forwarded clock level per slot, slot 0 in bit 0
`define LVSL_FWD_CLK_PATTERN 7'h0f

// ==========================================================
// Timing
`define LVSL_REF_PERIOD_PS 64'd4000
`define LVSL_PLL_LOCK_MS 64'd10
`define LVSL_PLL_LOCK_CYCLES \
  (`LVSL_PLL_LOCK_MS * 64'd1000000000 / `LVSL_REF_PERIOD_PS)
`define LVSL_SHIFT_MAX_PERIOD_NS 64'd50
`define LVSL_SHIFT_GAP_CYCLES \
  ((`LVSL_SHIFT_MAX_PERIOD_NS * 64'd1000 + `LVSL_REF_PERIOD_PS - 64'd1) \
  / `LVSL_REF_PERIOD_PS)
`define LVSL_RX_FRAME_GAP_CYCLES 16'h0100
`define LVSL_RX_STROBE_HIGH_CYCLES 4'h2

`endif

// ==== rtl/lvsl_pkg.sv ====
`include "lvsl_params.svh"

package lvsl_pkg;

  // ========================================================
  // Parallel pixel word, red in the low bits
  typedef struct packed {
    logic pixel_valid_marker;
    logic frame_sync;
    logic line_sync;
    logic [`LVSL_COLOR_BITS-1:0] blue;
    logic [`LVSL_COLOR_BITS-1:0] green;
    logic [`LVSL_COLOR_BITS-1:0] red;
  } lvsl_pixel_t;

  // ========================================================
  // Differential pairs
  typedef struct packed {
    logic [`LVSL_CHANNELS-1:0] p;
    logic [`LVSL_CHANNELS-1:0] n;
  } lvsl_data_pairs_t;

  typedef struct packed {
    logic p;
    logic n;
  } lvsl_clk_pair_t;

  // ========================================================
  // Receiver output strobe
  typedef enum logic [0:0] {
    STB_IDLE,
    STB_HIGH
  } lvsl_strobe_state_t;

endpackage

// ==== rtl/lvsl_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Three-stage synchroniser, output follows once stages 2 and 3 agree
module lvsl_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] dout_reg;
  logic [WIDTH-1:0] dout_next;

  assign dout_next = (s2_reg & s3_reg) | (dout_reg & (s2_reg ^ s3_reg));
  assign dout = dout_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      dout_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      dout_reg <= dout_next;
    end
  end

endmodule

`default_nettype wire

// ==== verif/lvsl_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host controller: free shift clock, words change mid-phase
module lvsl_host_model
  import lvsl_pkg::*;
(
  // Control
  input wire logic [7:0] quarter_ns,
  input wire lvsl_pixel_t word_at_rise,
  input wire lvsl_pixel_t word_at_fall,
  // Parallel side
  output logic shift_clk,
  output lvsl_pixel_t pixel
);
  initial begin
    shift_clk = 1'b0;
    pixel = '0;
    // Keep pin changes off the reference clock edges
    #1.3;
    forever begin
      #(quarter_ns) pixel = word_at_rise;
      #(quarter_ns) shift_clk = 1'b1;
      #(quarter_ns) pixel = word_at_fall;
      #(quarter_ns) shift_clk = 1'b0;
    end
  end
endmodule

`default_nettype wire

// ==== verif/lvsl_link_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Port checks for the link
module lvsl_link_assertions
  import lvsl_pkg::*;
(
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic link_clk,
  // Sleep requests
  input wire logic tx_sleep_request_n,
  input wire logic rx_sleep_request_n,
  // Serial side
  input wire lvsl_data_pairs_t serial_data_out_pairs,
  input wire logic [2:0] serial_data_out_oe,
  input wire lvsl_clk_pair_t forwarded_clock_out,
  input wire logic forwarded_clock_out_oe,
  // Parallel side
  input wire lvsl_pixel_t parallel_rx_outputs,
  input wire logic rx_shift_clock_out
);
  // ========================================================
  // Forwarded clock frame: four slots high, three low
  sequence fwd_high_s;
    forwarded_clock_out.p [*4];
  endsequence
  sequence fwd_low_s;
    !forwarded_clock_out.p [*3];
  endsequence

  tx_sleep_bound_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $fell(tx_sleep_request_n) |-> ##[1:25]
    (serial_data_out_oe == 3'h0 && !forwarded_clock_out_oe))
    else $error("transmitter still driving after sleep");
  tx_tristate_a: assert property (
    @(posedge link_clk) disable iff (!rstn)
    serial_data_out_oe == 3'h0 |-> serial_data_out_pairs == 6'h00)
    else $error("released data pairs not idle");
  tx_diff_pair_a: assert property (
    @(posedge link_clk) disable iff (!rstn) forwarded_clock_out_oe |->
    (forwarded_clock_out.n == ~forwarded_clock_out.p &&
    serial_data_out_pairs.n == ~serial_data_out_pairs.p))
    else $error("pair halves not complementary");
  slot_frame_a: assert property (
    @(posedge link_clk) disable iff (!rstn || !forwarded_clock_out_oe)
    $rose(forwarded_clock_out.p) && $past(forwarded_clock_out_oe) |->
    fwd_high_s ##1 fwd_low_s ##1
    forwarded_clock_out.p)
    else $error("frame not seven slots");
  rx_sleep_bound_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $fell(rx_sleep_request_n) |-> ##[1:8]
    (parallel_rx_outputs == 21'h0 && !rx_shift_clock_out))
    else $error("receiver slow to enter sleep");
  rx_sleep_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !rx_sleep_request_n [*8] |->
    parallel_rx_outputs == 21'h0 && !rx_shift_clock_out)
    else $error("receiver outputs not low in sleep");
  strobe_width_a: assert property (
    @(posedge ref_clk) disable iff (!rstn || !rx_sleep_request_n)
    $rose(rx_shift_clock_out) |-> rx_shift_clock_out [*3] ##1
    !rx_shift_clock_out)
    else $error("receiver strobe width wrong");
  rx_data_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rstn || !rx_sleep_request_n)
    !$stable(parallel_rx_outputs) |->
    $rose(rx_shift_clock_out) || parallel_rx_outputs == 21'h0)
    else $error("receiver data changed without strobe");
endmodule

bind lvsl_link lvsl_link_assertions u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .link_clk(link_clk),
  .tx_sleep_request_n(tx_sleep_request_n),
  .rx_sleep_request_n(rx_sleep_request_n),
  .serial_data_out_pairs(serial_data_out_pairs),
  .serial_data_out_oe(serial_data_out_oe),
  .forwarded_clock_out(forwarded_clock_out),
  .forwarded_clock_out_oe(forwarded_clock_out_oe),
  .parallel_rx_outputs(parallel_rx_outputs),
  .rx_shift_clock_out(rx_shift_clock_out)
);

`default_nettype wire

// ==== verif/lvsl_link_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module lvsl_link_tb
  import lvsl_pkg::*;
;
  localparam logic [31:0] LOCK = 32'h00000032;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rstn = 1'b0;
  logic edge_sel = 1'b0;
  logic tx_sleep_n = 1'b1;
  logic rx_sleep_n = 1'b1;
  logic [7:0] quarter = 8'h0a;
  lvsl_pixel_t w_rise = '0;
  lvsl_pixel_t w_fall = '0;
  lvsl_pixel_t tx_word, rx_word;
  lvsl_data_pairs_t tx_data, rx_data;
  lvsl_clk_pair_t tx_fwd, rx_fwd;
  logic [2:0] data_oe;
  logic shift_clk, fwd_oe, rx_strobe, tx_locked, rx_locked;
  logic [31:0] seed = 32'h00012adb;
  logic [20:0] exp_q[$];
  int errors = 0;
  int compares = 0;

  always #2 ref_clk = ~ref_clk;
  always #7.5 link_clk = ~link_clk;

  // Cable: a released pair reads the inverse of its cleared output, so both halves read high
  assign rx_data = {(tx_data.p & data_oe) | (~tx_data.p & ~data_oe),
    (tx_data.n & data_oe) | (~tx_data.n & ~data_oe)};
  assign rx_fwd = fwd_oe ? tx_fwd : ~tx_fwd;

  lvsl_link #(.PLL_LOCK_CYCLES(LOCK), .RX_FRAME_GAP_CYCLES(16'h0040)) uut (
    .ref_clk(ref_clk), .rstn(rstn), .link_clk(link_clk),
    .parallel_tx_inputs(tx_word), .tx_shift_clock_in(shift_clk),
    .strobe_edge_select(edge_sel), .tx_sleep_request_n(tx_sleep_n),
    .serial_data_out_pairs(tx_data), .serial_data_out_oe(data_oe),
    .forwarded_clock_out(tx_fwd), .forwarded_clock_out_oe(fwd_oe),
    .serial_data_in_pairs(rx_data), .forwarded_clock_in(rx_fwd),
    .rx_sleep_request_n(rx_sleep_n), .parallel_rx_outputs(rx_word),
    .rx_shift_clock_out(rx_strobe), .tx_locked(tx_locked),
    .rx_locked(rx_locked));

  lvsl_host_model host (.quarter_ns(quarter), .word_at_rise(w_rise),
    .word_at_fall(w_fall), .shift_clk(shift_clk), .pixel(tx_word));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp_word(input logic [20:0] got, input logic [20:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_time(input logic [31:0] got, input logic [31:0] lim);
    compares++;
    if (got > lim) begin
      errors++;
      $display("[FAIL] %0t cycles %h limit %h", $time, got, lim);
    end
  endtask

  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wait_lock();
    int n;
    n = 0;
    while (!(tx_locked === 1'b1 && rx_locked === 1'b1) && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    cmp_time(n, 3 * LOCK + 100);
  endtask

  // Collect one frame off the wire, slot 0 first
  task automatic grab_frame(output logic [20:0] w);
    @(negedge link_clk);
    while (tx_fwd.p !== 1'b0) @(negedge link_clk);
    while (tx_fwd.p !== 1'b1) @(negedge link_clk);
    for (int s = 0; s < 7; s++) begin
      for (int c = 0; c < 3; c++) w[c * 7 + s] = tx_data.p[c];
      @(negedge link_clk);
    end
  endtask

  task automatic send_check(input logic [20:0] a, input logic [20:0] b);
    logic [20:0] frame;
    @(negedge ref_clk);
    w_rise = a;
    w_fall = b;
    exp_q.push_back(edge_sel ? a : b);
    // Older words may still be in flight
    repeat (8) @(negedge rx_strobe);
    grab_frame(frame);
    cmp_word(frame, exp_q[0]);
    @(negedge rx_strobe);
    cmp_word(rx_word, exp_q.pop_front());
  endtask

  initial begin
    int n;
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    wait_lock();
    $display("test lock done");
    repeat (6) send_check(21'(rnd()), 21'(rnd()));
    $display("test falling strobe done");
    @(negedge ref_clk);
    edge_sel = 1'b1;
    send_check(21'h1fffff, 21'h000000);
    send_check(21'h000000, 21'h1fffff);
    repeat (2) send_check(21'(rnd()), 21'(rnd()));
    quarter = 8'h05;
    repeat (3) send_check(21'(rnd()), 21'(rnd()));
    $display("test rising strobe done");
    @(negedge ref_clk);
    rx_sleep_n = 1'b0;
    n = 0;
    while ((rx_word !== 21'h0 || rx_strobe !== 1'b0) && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    cmp_time(n, 32'h000000fa);
    w_rise = 21'(rnd());
    repeat (60) @(negedge ref_clk);
    cmp_word(rx_word, 21'h0);
    tx_sleep_n = 1'b0;
    n = 0;
    while ((data_oe !== 3'h0 || fwd_oe !== 1'b0) && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    cmp_time(n, 32'h00000019);
    cmp_word(21'(tx_data), 21'h0);
    tx_sleep_n = 1'b1;
    rx_sleep_n = 1'b1;
    wait_lock();
    send_check(21'(rnd()), 21'(rnd()));
    $display("test sleep done");
    conclude();
  end

  initial begin
    #100000;
    errors++;
    conclude();
  end
endmodule

`default_nettype wire
